// [core/scd_pkg.sv]
// Shared constants of the card clock divider and its host controller
package scd_pkg;
  // ----------------------------------------------------------------
  // Divider selection codes, formed as {bit0, bit1} of the byte
  // ----------------------------------------------------------------
  localparam logic [1:0] RATIO_OFF  = 2'h0;
  localparam logic [1:0] RATIO_DIV1 = 2'h1;
  localparam logic [1:0] RATIO_DIV2 = 2'h2;
  localparam logic [1:0] RATIO_DIV4 = 2'h3;

  // ----------------------------------------------------------------
  // Command byte fields (bit 7 travels first)
  // ----------------------------------------------------------------
  localparam int BIT_RATIO_HI = 0;
  localparam int BIT_RATIO_LO = 1;
  localparam int BIT_SLOPE    = 2;
  localparam int BIT_MODE     = 3;
  localparam int BIT_RESET    = 4;
  localparam int ADDR_LSB     = 5;
  localparam int ADDR_W       = 3;
  localparam int FRAME_BITS   = 8;

  // Readback byte fields
  localparam int ST_CARD_OV = 7;
  localparam int ST_CARD_UV = 6;
  localparam int ST_BAT_OV  = 5;
  localparam int ST_BAT_UV  = 4;
  localparam int ST_CRST    = 3;
  localparam int ST_SLOPE   = 2;

  // Reset values of the device settings
  localparam logic [1:0] RST_RATIO = RATIO_OFF;
  localparam logic       RST_SLOPE = 1'b0;
  localparam logic       RST_MODE  = 1'b0;
  localparam logic       RST_CRST  = 1'b0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 40_000_000;
  localparam int CARD_CLK_MAX_HZ = 20_000_000;
  localparam int CLKIN_MIN_DIV   = (CLK_HZ + CARD_CLK_MAX_HZ - 1) / CARD_CLK_MAX_HZ;
  localparam int CLKIN_DIV_DEF   = 4;
  localparam int SPI_HALF_DEF    = 8;
  localparam int RATIO_PULSES    = 4;
  localparam int SYNC_MARGIN     = 4;

  // ----------------------------------------------------------------
  // Host controller register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] WB_TX       = 8'h00;
  localparam logic [7:0] WB_STAT     = 8'h04;
  localparam logic [7:0] WB_IRQ_STAT = 8'h08;
  localparam logic [7:0] WB_IRQ_CLR  = 8'h0c;
  localparam logic [7:0] WB_IRQ_EN   = 8'h10;
  localparam int STAT_BUSY   = 0;
  localparam int STAT_INT    = 1;
  localparam int STAT_RX_LSB = 8;
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_FAULT   = 1;
endpackage

// [core/scd_if.sv]
// Link between the card clock divider and its host controller
interface scd_if;
  logic clk_in;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic int_n;
  modport dev (input clk_in, input cs_n, input sclk, input mosi, output miso, output int_n);
  modport hst (output clk_in, output cs_n, output sclk, output mosi, input miso, input int_n);
endinterface

// [core/scd_device.sv]
// Card clock divider with serial programming port and supply supervision
//
// How it works
// - Code selects low, divide 1, 2, 4
// - Final flop gives 50% duty
// - Ratio switch within four input pulses
// - Host clock duty 46-56% for ratio 1
// - Host keeps card clock at most 20 MHz
// - Host input clock at most 20 MHz
// - Slope from command byte, ratio-independent
// - Slope changeable at any time
// - Slope write also loads card reset from bit 4
// - Bit 2 taken at chip select rise, bit 3 at an input fall
// - Input clock, bit 0 steered by mode
// - Card supply fault sets status, interrupt
// - Battery fault updates readback status bits
// - Settings latch on chip select rise
module scd_device
  import scd_pkg::*;
#(
  parameter logic [ADDR_W-1:0] CHIP_ADDR = 3'h3   // Arbitrary value
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  scd_if.dev        link,
  input  wire logic card_over_v,
  input  wire logic card_under_v,
  input  wire logic bat_over_v,
  input  wire logic bat_under_v,
  output logic      card_clock_out,
  output logic      gentle_edge_rate,
  output logic      sharp_edge_rate,
  output logic      card_reset_line
);
  import scd_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] cin_s;
  logic [1:0] cs_s;
  logic [1:0] sck_s;
  logic [1:0] mosi_s;
  logic [3:0] flt_s0;
  logic [3:0] flt_s1;
  logic       cin_d;
  logic       cs_d;
  logic       sck_d;

  // Two flops per pin, then a third copy of input clock, chip select and serial clock for edge detection
  always_ff @(posedge clk) begin
    cin_s  <= {cin_s[0], link.clk_in};
    cs_s   <= {cs_s[0], link.cs_n};
    sck_s  <= {sck_s[0], link.sclk};
    mosi_s <= {mosi_s[0], link.mosi};
    flt_s0 <= {card_over_v, card_under_v, bat_over_v, bat_under_v};
    flt_s1 <= flt_s0;
    cin_d  <= cin_s[1];
    cs_d   <= cs_s[1];
    sck_d  <= sck_s[1];
  end

  // Edge strobes, all from the second flop onward
  wire in_rise  = cin_s[1] & ~cin_d;
  wire in_fall  = ~cin_s[1] & cin_d;
  wire cs_fall  = ~cs_s[1] & cs_d;
  wire cs_rise  = cs_s[1] & ~cs_d;
  wire sck_rise = sck_s[1] & ~sck_d;
  wire sck_fall = ~sck_s[1] & sck_d;

  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  logic [7:0] shift_q;
  logic [3:0] bcnt_q;
  logic [7:0] tx_q;
  logic [1:0] ratio_q;
  logic [1:0] pend_q;
  logic       slope_q;
  logic       mode_q;
  logic       b0_q;
  logic       crst_q;
  logic [1:0] card_flt_q;
  logic [1:0] card_flt_d;
  logic       int_n_q;

  wire       frame_ok = cs_rise & (bcnt_q == 4'(FRAME_BITS));
  wire       addr_hit = shift_q[ADDR_LSB +: ADDR_W] == CHIP_ADDR;
  wire [7:0] status_b = {card_flt_q, flt_s1[1:0], crst_q, slope_q, ratio_q};

  // Shift in on clock rise, out on fall; input cleared and readback loaded at frame start
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shift_q <= 8'h00;
      bcnt_q  <= 4'h0;
      tx_q    <= 8'h00;
    end else if (cs_fall) begin
      shift_q <= 8'h00;
      bcnt_q  <= 4'h0;
      tx_q    <= status_b;
    end else if (!cs_s[1]) begin
      if (sck_rise && bcnt_q != 4'(FRAME_BITS)) begin
        shift_q <= {shift_q[6:0], mosi_s[1]};
        bcnt_q  <= bcnt_q + 4'h1;
      end
      if (sck_fall) begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // Latch settings only for a whole byte addressed to this chip
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_q  <= RST_RATIO;
      slope_q <= RST_SLOPE;
      mode_q  <= RST_MODE;
      b0_q    <= 1'b0;
      crst_q  <= RST_CRST;
    end else if (frame_ok && addr_hit) begin
      pend_q  <= {shift_q[BIT_RATIO_HI], shift_q[BIT_RATIO_LO]};
      slope_q <= shift_q[BIT_SLOPE];
      mode_q  <= shift_q[BIT_MODE];
      b0_q    <= shift_q[BIT_RATIO_HI];
      crst_q  <= shift_q[BIT_RESET];
    end
  end

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  logic div_q;
  logic cnt_q;
  logic mode_on_q;

  // A new ratio or mode is taken only at an input fall inside a low
  // card clock phase, so no runt phase ever reaches the card; the wait
  // stays inside one /4 period. Unchanged settings never restart it.
  wire pend_chg = (pend_q != ratio_q) | (mode_q != mode_on_q);
  wire boundary = pend_chg & in_fall & ((ratio_q == RATIO_DIV1) | ~div_q);

  // Both divided ratios toggle on input rises only, hence 50% duty
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ratio_q   <= RST_RATIO;
      mode_on_q <= RST_MODE;
      div_q     <= 1'b0;
      cnt_q     <= 1'b0;
    end else if (boundary) begin
      ratio_q   <= pend_q;
      mode_on_q <= mode_q;
      div_q     <= 1'b0;
      cnt_q     <= 1'b0;
    end else if (ratio_q == RATIO_DIV1) begin
      div_q <= cin_s[1];
    end else if (in_rise) begin
      case (ratio_q)
        RATIO_DIV2: begin
          div_q <= ~div_q;
        end
        RATIO_DIV4: begin
          cnt_q <= ~cnt_q;
          if (cnt_q) begin
            div_q <= ~div_q;
          end
        end
        default: begin
          div_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Card pins
  // ----------------------------------------------------------------
  // Mode picks divided input clock or the static bit 0 level
  wire clk_src = mode_on_q ? b0_q : div_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      card_clock_out   <= 1'b0;
      gentle_edge_rate <= 1'b1;
      sharp_edge_rate  <= 1'b0;
      card_reset_line  <= RST_CRST;
    end else begin
      card_clock_out   <= clk_src;
      gentle_edge_rate <= ~slope_q;
      sharp_edge_rate  <= slope_q;
      card_reset_line  <= crst_q;
    end
  end

  // ----------------------------------------------------------------
  // Supply supervision
  // ----------------------------------------------------------------
  // Sticky card faults; a fresh fault wins over the read-clear
  assign card_flt_d = flt_s1[3:2] | (card_flt_q & {2{~frame_ok}});

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      card_flt_q <= 2'h0;
      int_n_q    <= 1'b1;
    end else begin
      card_flt_q <= card_flt_d;
      int_n_q    <= ~(|card_flt_q);
    end
  end

  assign link.miso  = tx_q[7];
  assign link.int_n = int_n_q;
endmodule // scd_device

// [core/scd_host.sv]
// Host controller: input clock source, serial master, register slave
module scd_host
  import scd_pkg::*;
#(
  parameter int CLKIN_DIV = CLKIN_DIV_DEF,
  parameter int SPI_HALF  = SPI_HALF_DEF
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_w,
  output logic      [31:0] wb_dat_r,
  output logic             wb_ack,
  output logic             irq,
  scd_if.hst               link
);
  import scd_pkg::*;

  // Wait after a frame so a new ratio has reached the card clock
  localparam int SETTLE_CYC = RATIO_PULSES * CLKIN_DIV + SYNC_MARGIN;

  typedef enum logic [2:0] {S_IDLE, S_LOW, S_HIGH, S_TRAIL, S_SETTLE} scd_state_e;

  // ----------------------------------------------------------------
  // Input clock: even division keeps 50% duty and at most 20 MHz
  // ----------------------------------------------------------------
  logic [15:0] cdiv_q;
  logic        clk_in_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cdiv_q   <= 16'h0000;
      clk_in_q <= 1'b0;
    end else if (cdiv_q == 16'(CLKIN_DIV / 2 - 1)) begin
      cdiv_q   <= 16'h0000;
      clk_in_q <= ~clk_in_q;
    end else begin
      cdiv_q <= cdiv_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Bus slave decode
  // ----------------------------------------------------------------
  logic [1:0]  miso_s;
  logic [1:0]  int_s;
  scd_state_e  st_q;
  logic [15:0] tmr_q;
  logic [2:0]  bits_q;
  logic [7:0]  sh_q;
  logic [7:0]  rx_q;
  logic [7:0]  rxb_q;
  logic [7:0]  txb_q;
  logic [1:0]  irq_st_q;
  logic [1:0]  irq_en_q;
  logic        done;

  wire        req   = wb_cyc & wb_stb & ~wb_ack;
  wire        wr    = req & wb_we & wb_sel[0];
  wire        start = wr & (wb_adr == WB_TX) & (st_q == S_IDLE);
  wire        clr   = wr & (wb_adr == WB_IRQ_CLR);
  wire [1:0]  evt   = {~int_s[1], done};
  wire        tmo   = tmr_q == 16'(SPI_HALF - 1);
  wire [31:0] stat  = {16'h0000, rxb_q, 6'h00, ~int_s[1], st_q != S_IDLE};
  wire [31:0] rdat  = (wb_adr == WB_TX)       ? {24'h000000, txb_q} :
                      (wb_adr == WB_STAT)     ? stat :
                      (wb_adr == WB_IRQ_STAT) ? {30'h0, irq_st_q} :
                      (wb_adr == WB_IRQ_EN)   ? {30'h0, irq_en_q} : 32'h0;

  // One-cycle answer; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wb_ack   <= 1'b0;
      wb_dat_r <= 32'h0;
      irq_en_q <= 2'h0;
      irq_st_q <= 2'h0;
      irq      <= 1'b0;
      miso_s   <= 2'h0;
      int_s    <= 2'h3;
    end else begin
      wb_ack   <= req;
      wb_dat_r <= rdat;
      if (wr && wb_adr == WB_IRQ_EN) begin
        irq_en_q <= wb_dat_w[1:0];
      end
      irq_st_q <= evt | (irq_st_q & ~(clr ? wb_dat_w[1:0] : 2'h0));  // Set beats clear
      irq      <= |(irq_st_q & irq_en_q);
      miso_s   <= {miso_s[0], link.miso};
      int_s    <= {int_s[0], link.int_n};
    end
  end

  // ----------------------------------------------------------------
  // Serial master
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q      <= S_IDLE;
      tmr_q     <= 16'h0000;
      bits_q    <= 3'h0;
      sh_q      <= 8'h00;
      rx_q      <= 8'h00;
      rxb_q     <= 8'h00;
      txb_q     <= 8'h00;
      done      <= 1'b0;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      link.mosi <= 1'b0;
    end else begin
      done  <= 1'b0;
      tmr_q <= tmr_q + 16'h0001;
      case (st_q)
        S_IDLE: begin
          if (start) begin
            txb_q     <= wb_dat_w[7:0];
            sh_q      <= {wb_dat_w[6:0], 1'b0};
            link.mosi <= wb_dat_w[7];
            link.cs_n <= 1'b0;
            bits_q    <= 3'h0;
            tmr_q     <= 16'h0000;
            st_q      <= S_LOW;
          end
        end
        S_LOW: begin
          if (tmo) begin
            link.sclk <= 1'b1;
            rx_q      <= {rx_q[6:0], miso_s[1]};
            tmr_q     <= 16'h0000;
            st_q      <= S_HIGH;
          end
        end
        S_HIGH: begin
          if (tmo) begin
            link.sclk <= 1'b0;
            tmr_q     <= 16'h0000;
            bits_q    <= bits_q + 3'h1;
            link.mosi <= sh_q[7];
            sh_q      <= {sh_q[6:0], 1'b0};
            st_q      <= (bits_q == 3'h7) ? S_TRAIL : S_LOW;
          end
        end
        S_TRAIL: begin
          if (tmo) begin
            link.cs_n <= 1'b1;
            rxb_q     <= rx_q;
            tmr_q     <= 16'h0000;
            st_q      <= S_SETTLE;
          end
        end
        S_SETTLE: begin
          if (tmr_q == 16'(SETTLE_CYC - 1)) begin
            done <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  assign link.clk_in = clk_in_q;
endmodule // scd_host

// [dv/scd_assertions.sv]
// Concurrent checks on the link between the card clock divider and its host
module scd_assertions
  import scd_pkg::*;
#(
  parameter int CLKIN_DIV = CLKIN_DIV_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_in,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic int_n,
  input wire logic card_over_v,
  input wire logic card_under_v,
  input wire logic card_clock_out,
  input wire logic gentle_edge_rate,
  input wire logic sharp_edge_rate,
  input wire logic card_reset_line
);
  logic [3:0] bits_q;
  logic [3:0] bits_d;
  logic [3:0] since_q;
  logic [3:0] since_d;
  logic [7:0] hi_q;
  logic [7:0] hi_d;
  logic       sclk_q;
  logic       cs_q;

  // ------------------------------------------------------------
  // Helper counters
  // ------------------------------------------------------------
  assign bits_d  = cs_n ? 4'h0 : bits_q + {3'h0, sclk & ~sclk_q};
  assign since_d = (cs_n & ~cs_q) ? 4'h0 : since_q + {3'h0, since_q != 4'hf};
  assign hi_d    = clk_in ? hi_q + 8'h1 : 8'h0;

  // Restart on reset so no stale frame count leaks across
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bits_q  <= 4'h0;
      since_q <= 4'hf;
      hi_q    <= 8'h0;
      sclk_q  <= 1'b0;
      cs_q    <= 1'b1;
    end else begin
      bits_q  <= bits_d;
      since_q <= since_d;
      hi_q    <= hi_d;
      sclk_q  <= sclk;
      cs_q    <= cs_n;
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_int_low;
    ##[1:6] !int_n;
  endsequence
  sequence s_hi_two;
    card_clock_out [*2];
  endsequence
  sequence s_lo_two;
    !card_clock_out [*2];
  endsequence

  a_clkin_half: assert property ($fell(clk_in) |-> hi_q == CLKIN_DIV / 2)
    else $error("input clock high phase wrong");
  a_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock active outside frame");
  a_mosi_hold: assert property (sclk |-> $stable(mosi))
    else $error("data moved while serial clock high");
  a_frame_bits: assert property ($rose(cs_n) |-> bits_q == FRAME_BITS)
    else $error("frame closed without eight bits");
  a_slope_excl: assert property (gentle_edge_rate != sharp_edge_rate)
    else $error("edge rate outputs not exclusive");
  a_latch_win: assert property ($changed(card_reset_line) || $changed(sharp_edge_rate)
    |-> since_q inside {[1:8]})
    else $error("settings changed away from frame end");
  a_fault_int: assert property ($rose(card_over_v | card_under_v) |-> s_int_low)
    else $error("card supply fault gave no interrupt");
  a_int_hold: assert property ($rose(int_n) |-> since_q <= 4'h8)
    else $error("interrupt released without readback");
  a_cc_high: assert property ($rose(card_clock_out) |-> s_hi_two)
    else $error("card clock high phase shortened");
  a_cc_low: assert property ($fell(card_clock_out) |-> s_lo_two)
    else $error("card clock low phase shortened");
endmodule // scd_assertions

// [dv/scd_test.sv]
// Self-checking bench joining host controller and card clock divider
module scd_test;
  timeunit 1ns;
  timeprecision 1ps;
  import scd_pkg::*;

  localparam logic [2:0] ADR = 3'h5; // Arbitrary chip address
  logic        clk;
  logic        sys_rst;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat_w;
  logic [31:0] wb_dat_r;
  logic        wb_ack;
  logic        irq;
  logic        card_over_v;
  logic        card_under_v;
  logic        bat_over_v;
  logic        bat_under_v;
  logic        card_clock_out;
  logic        gentle_edge_rate;
  logic        sharp_edge_rate;
  logic        card_reset_line;
  logic [31:0] q;
  int          n_errors;
  int          n_compared;
  int          hi;
  int          per;

  scd_if u_scd_if();
  scd_host u_scd_host (.clk(clk), .sys_rst(sys_rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .irq(irq), .link(u_scd_if.hst));
  scd_device #(.CHIP_ADDR(ADR)) u_scd_device (.clk(clk), .sys_rst(sys_rst),
    .link(u_scd_if.dev), .card_over_v(card_over_v), .card_under_v(card_under_v),
    .bat_over_v(bat_over_v), .bat_under_v(bat_under_v), .card_clock_out(card_clock_out),
    .gentle_edge_rate(gentle_edge_rate), .sharp_edge_rate(sharp_edge_rate),
    .card_reset_line(card_reset_line));
  scd_assertions u_scd_assertions (.clk(clk), .sys_rst(sys_rst),
    .clk_in(u_scd_if.clk_in), .cs_n(u_scd_if.cs_n), .sclk(u_scd_if.sclk),
    .mosi(u_scd_if.mosi), .int_n(u_scd_if.int_n), .card_over_v(card_over_v),
    .card_under_v(card_under_v), .card_clock_out(card_clock_out),
    .gentle_edge_rate(gentle_edge_rate), .sharp_edge_rate(sharp_edge_rate),
    .card_reset_line(card_reset_line));

  // ------------------------------------------------------------
  // Clock and tasks
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // Classic single Wishbone cycle; waits for ack under a bound
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= w;
    wb_sel   <= 4'hf;
    wb_adr   <= a;
    wb_dat_w <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    q = wb_dat_r;
    if (n >= 50) n_errors++;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  // One byte frame, then poll until the host is idle again
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    wb(1'b1, WB_TX, {24'h0, b});
    do begin
      wb(1'b0, WB_STAT, 32'h0);
      n++;
    end while (q[STAT_BUSY] !== 1'b0 && n < 400);
    if (n >= 400) n_errors++;
  endtask

  function automatic logic [7:0] mk(logic [2:0] a, logic [1:0] c, logic s, logic r);
    return {a, r, 1'b0, s, c[0], c[1]};
  endfunction

  // High time and period of the card clock, in system clocks
  task automatic meas();
    int n;
    n = 0;
    hi = 0;
    per = 0;
    while (card_clock_out !== 1'b0 && n < 100) begin @(posedge clk); n++; end
    while (card_clock_out !== 1'b1 && n < 200) begin @(posedge clk); n++; end
    while (card_clock_out === 1'b1 && per < 100) begin @(posedge clk); hi++; per++; end
    while (card_clock_out === 1'b0 && per < 100) begin @(posedge clk); per++; end
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog: far above the few thousand cycles the tests need
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    summarize();
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    {sys_rst, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_w} = {1'b1, 47'h0f_0000_0000};
    {card_over_v, card_under_v, bat_over_v, bat_under_v} = 4'h0;
    n_errors = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'h9, {27'h0, card_clock_out, gentle_edge_rate, sharp_edge_rate, card_reset_line,
      u_scd_if.int_n});
    wb(1'b1, 8'h20, 32'hff);
    wb(1'b0, 8'h20, 32'h0);
    chk(32'h0, q);
    for (int c = 1; c < 4; c++) begin
      send(mk(ADR, c[1:0], c[0], c[1]));
      chk({~c[0], c[0], c[1]}, {gentle_edge_rate, sharp_edge_rate, card_reset_line});
      meas();
      chk(CLKIN_DIV_DEF << (c - 1), per);
      chk(CLKIN_DIV_DEF << (c - 1), hi * 2);
    end
    send(mk(ADR, 2'h3, 1'b0, 1'b0));
    meas();
    chk({30'(CLKIN_DIV_DEF * 4), 2'h2}, {per[29:0], gentle_edge_rate, sharp_edge_rate});
    send(mk(~ADR, 2'h1, 1'b1, 1'b1));
    meas();
    chk({16'h10, 16'h4}, {per[15:0], 13'h0, gentle_edge_rate, sharp_edge_rate,
      card_reset_line});
    for (int m = 0; m < 2; m++) begin
      send(m ? 8'(mk(ADR, 2'h2, 1'b0, 1'b0) | 8'h08) : mk(ADR, 2'h0, 1'b1, 1'b0));
      hi = 0;
      repeat (40) begin
        @(posedge clk);
        hi += int'(card_clock_out === 1'b1);
      end
      chk(m * 40, hi);
    end
    wb(1'b1, WB_IRQ_EN, 32'h0);
    card_over_v <= 1'b1;
    bat_under_v <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'h0, {31'h0, u_scd_if.int_n});
    wb(1'b0, WB_IRQ_STAT, 32'h0);
    chk(32'h2, {q[31:2], q[IRQ_FAULT], irq});
    wb(1'b1, WB_IRQ_EN, 32'h2);
    card_over_v <= 1'b0;
    repeat (10) @(posedge clk);
    chk(32'h1, {30'h0, u_scd_if.int_n, irq});
    send(mk(ADR, 2'h1, 1'b1, 1'b0));
    chk(32'h9, {28'h0, q[15:12]});
    chk(32'h1, {31'h0, u_scd_if.int_n});
    wb(1'b1, WB_IRQ_CLR, 32'h3);
    wb(1'b0, WB_IRQ_STAT, 32'h0);
    chk(32'h0, {q[30:0], irq});
    bat_under_v <= 1'b0;
    summarize();
  end
endmodule // scd_test
